/* File: hw/flash_prot_defs.vh */
// Purpose: constants for the flash security and protection register block
// Assumes: AXI4-Lite register window, 32-bit data, one register per aligned word
// Notes:   byte offsets inside the window; fields sit in the low byte
`ifndef FLASH_PROT_DEFS_VH
`define FLASH_PROT_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_SECURITY_OPTIONS 6'h00
`define OFS_BACKDOOR_GATE    6'h04
`define OFS_SECTOR_PROT      6'h08
`define OFS_FLASH_STATUS     6'h0C
`define OFS_IRQ_STATUS       6'h10
`define OFS_IRQ_CLEAR        6'h14
`define OFS_IRQ_ENABLE       6'h18

// ----------------------------------------
// field positions and encodings
// ----------------------------------------
`define BACKDOOR_EN_HI     7
`define BACKDOOR_EN_LO     6
`define LOCK_STATE_HI      1
`define LOCK_STATE_LO      0
`define ENC_ENABLED        2'h2
`define ENC_UNSECURED      2'h3
`define KEY_WRITE_SEL_BIT  5
`define PROTECT_OPEN_BIT   0
`define PROTECT_SIZE_HI    7
`define PROTECT_SIZE_LO    1
`define VIOL_FLAG_BIT      5
`define SIZE_FULL_LIMIT    7'h40

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define IRQ_VIOL_BIT    0
`define IRQ_MASS_BIT    1
`define IRQ_UNLOCK_BIT  2
`define IRQ_WIDTH       3

// ----------------------------------------
// protection geometry: 2 KB steps, 128 KB array
// ----------------------------------------
`define STEP_SHIFT     11
`define ARRAY_TOP      18'h20000
`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2

`endif

/* File: hw/flash_prot.v */
// Purpose: security options, backdoor gate and sector protection registers of a flash controller
// Assumes: AXI4-Lite slave; configuration bytes valid while load_strobe pulses during reset sequencing
// Notes:   array write and erase requests arrive on plain ports; this block judges and routes them
//
// Functional notes
// [RULE1] security options load from stored byte at reset sequence, read-only afterwards
// [RULE2] backdoor access enabled only when backdoor enable field equals 10
// [RULE3] lock state reports secured only for encoding 10, all else unsecured
// [RULE4] successful backdoor unlock forces lock state field to an unsecured code
// [RULE5] key write select writable only while backdoor enable field is enabled
// [RULE6] key select 0 routes array writes to commands, 1 captures them as keys
// [RULE7] array reads keep working while key write select is set
// [RULE8] other config bits read zero and ignore writes
// [RULE9] protection writes apply only when they enlarge the protected region
// [RULE10] protection register loads from stored protection byte at reset sequence
// [RULE11] software unprotects config sector before reprogramming stored protection byte
// [RULE12] program or erase inside protected region refused, violation flag set
// [RULE13] mass erase refused while any sector is protected
// [RULE14] open bit 0 protects the whole 128 KB array
// [RULE15] open bit 1: size field 0x00-0x3F still protects the whole array
// [RULE16] sizes 0x40-0x7F shrink range 2 KB each from 126 KB, 0x7F none
// [RULE17] enlarging means new protected top no lower than current, by effective range
// [RULE18] violation flag cleared by writing 1 only; no command launch while set
//
// The register offsets and the AXI4-Lite register port were decided locally.
`include "flash_prot_defs.vh"

module flash_prot #(
  parameter ADDR_W = 17
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // configuration load during reset sequencing
  input wire load_strobe,
  input wire [7:0] stored_options_byte,
  input wire [7:0] stored_protection_byte,
  // AXI4-Lite write address
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // array write / erase requests from the array port
  input wire array_wr,
  input wire array_rd,
  input wire array_erase,
  input wire mass_erase,
  input wire [ADDR_W-1:0] array_addr,
  input wire key_match,
  // routed results
  output wire cmd_write,
  output wire key_write,
  output wire array_read_ok,
  output wire erase_go,
  output wire mass_erase_go,
  output wire cmd_launch_ok,
  // interrupt
  output wire irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] security_options;
  reg key_write_select;
  reg [7:0] sector_protection;
  reg protect_violation_flag;
  reg unlocked;
  reg [`IRQ_WIDTH-1:0] irq_status;
  reg [`IRQ_WIDTH-1:0] irq_enable;
  reg [5:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  // ----------------------------------------
  // protected top: byte count of the region from the array base
  // ----------------------------------------
  function [17:0] prot_top;
    input [7:0] prot;
    reg [6:0] size;
    begin
      size = prot[`PROTECT_SIZE_HI:`PROTECT_SIZE_LO];
      if (!prot[`PROTECT_OPEN_BIT]) begin
        prot_top = `ARRAY_TOP; // RULE14
      end else if (size < `SIZE_FULL_LIMIT) begin
        prot_top = `ARRAY_TOP; // RULE15
      end else begin
        // 0x40 -> 126 KB ... 0x7F -> 0 KB
        prot_top = {1'b0, 6'h3F - size[5:0], {`STEP_SHIFT{1'b0}}}; // RULE16
      end
    end
  endfunction

  wire [17:0] cur_top = prot_top(sector_protection);
  wire any_protected = (cur_top != 18'h00000);
  wire addr_protected = ({{(18-ADDR_W){1'b0}}, array_addr} < cur_top);
  wire backdoor_enabled =
    (security_options[`BACKDOOR_EN_HI:`BACKDOOR_EN_LO] == `ENC_ENABLED); // RULE2
  wire [1:0] lock_code = unlocked ? `ENC_UNSECURED : security_options[`LOCK_STATE_HI:`LOCK_STATE_LO]; // RULE4
  wire secured = (lock_code == `ENC_ENABLED); // RULE3

  // ----------------------------------------
  // array request routing
  // ----------------------------------------
  // a refused request never reaches the array; the flag records it instead.
  // erase requests ignore key mode, only writes change meaning there
  assign cmd_launch_ok = !protect_violation_flag; // RULE18
  wire prog_req = array_wr && !key_write_select;
  wire viol_prog = prog_req && addr_protected; // RULE12
  wire viol_erase = array_erase && addr_protected; // RULE12
  wire viol_mass = mass_erase && any_protected; // RULE13
  assign cmd_write = prog_req && !addr_protected && cmd_launch_ok; // RULE6
  assign key_write = array_wr && key_write_select; // RULE6
  assign array_read_ok = array_rd; // RULE7
  assign erase_go = array_erase && !addr_protected && cmd_launch_ok;
  assign mass_erase_go = mass_erase && !any_protected && cmd_launch_ok; // RULE13
  wire viol_event = viol_prog | viol_erase | viol_mass;
  wire unlock_event = key_write && key_match && backdoor_enabled && !unlocked;

  // ----------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------
  // one outstanding write and read; address and data latch in either order.
  // a write outside the map still completes, so a stray access cannot stall the bus
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire wr_lane0 = wr_fire && w_strb[0];

  wire wr_cfg = wr_lane0 && (aw_addr == `OFS_BACKDOOR_GATE);
  wire wr_prot = wr_lane0 && (aw_addr == `OFS_SECTOR_PROT);
  wire wr_stat = wr_lane0 && (aw_addr == `OFS_FLASH_STATUS);
  wire wr_clr = wr_lane0 && (aw_addr == `OFS_IRQ_CLEAR);
  wire wr_en = wr_lane0 && (aw_addr == `OFS_IRQ_ENABLE);
  wire [17:0] new_top = prot_top(w_data[7:0]);

  // every decoded offset answers OKAY; anything else in the window is a slave error
  function mapped;
    input [5:0] a;
    begin
      case (a)
        `OFS_SECURITY_OPTIONS: mapped = 1'b1;
        `OFS_BACKDOOR_GATE: mapped = 1'b1;
        `OFS_SECTOR_PROT: mapped = 1'b1;
        `OFS_FLASH_STATUS: mapped = 1'b1;
        `OFS_IRQ_STATUS: mapped = 1'b1;
        `OFS_IRQ_CLEAR: mapped = 1'b1;
        `OFS_IRQ_ENABLE: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_addr <= 6'h00;
      aw_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  reg [7:0] rd_byte;
  always @* begin
    case (s_axi_araddr)
      `OFS_SECURITY_OPTIONS: rd_byte = {security_options[7:6], 4'h0, lock_code}; // RULE1
      `OFS_BACKDOOR_GATE: rd_byte = {2'h0, key_write_select, 5'h00}; // RULE8
      `OFS_SECTOR_PROT: rd_byte = sector_protection;
      `OFS_FLASH_STATUS: rd_byte = {2'h0, protect_violation_flag, 5'h00};
      `OFS_IRQ_STATUS: rd_byte = {5'h00, irq_status};
      `OFS_IRQ_ENABLE: rd_byte = {5'h00, irq_enable};
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // register write acceptance
  // ----------------------------------------
  // ranges are compared, not encodings: 0x00 and 0x7D both mean the whole array,
  // and an open bit of 0 beats any size field; a bigger region means a higher top
  wire prot_grows = (new_top >= cur_top); // RULE9 RULE17
  wire prot_write_ok = wr_prot && prot_grows;
  // key select only moves while the loaded options enable the backdoor
  wire cfg_write_ok = wr_cfg && backdoor_enabled; // RULE5

  // ----------------------------------------
  // security options and unlock state
  // ----------------------------------------
  // software has no write path here; only the reset-sequence load and a backdoor unlock move these
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      security_options <= 8'h00;
      unlocked <= 1'b0;
    end else if (load_strobe) begin
      // reserved option bits forced to zero on load
      security_options <= {stored_options_byte[7:6], 4'h0, stored_options_byte[1:0]}; // RULE1
      unlocked <= 1'b0;
    end else if (unlock_event) begin
      unlocked <= 1'b1; // RULE4
    end
  end

  // ----------------------------------------
  // backdoor gate
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      key_write_select <= 1'b0;
    end else if (load_strobe) begin
      key_write_select <= 1'b0;
    end else if (cfg_write_ok) begin
      key_write_select <= w_data[`KEY_WRITE_SEL_BIT]; // RULE5
    end
  end

  // ----------------------------------------
  // sector protection
  // ----------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sector_protection <= 8'h00;
    end else if (load_strobe) begin
      sector_protection <= stored_protection_byte; // RULE10
    end else if (prot_write_ok) begin
      // writes that would shrink the region are dropped whole
      sector_protection <= w_data[7:0]; // RULE9 RULE17
    end
  end

  // ----------------------------------------
  // violation flag and interrupts
  // ----------------------------------------
  wire [`IRQ_WIDTH-1:0] irq_events = {unlock_event, viol_mass, viol_prog | viol_erase};
  // a write of 0 to the flag bit leaves it alone
  wire viol_clear = wr_stat && w_data[`VIOL_FLAG_BIT]; // RULE18

  // set wins over a clear that lands in the same cycle, so no event is lost
  reg [`IRQ_WIDTH-1:0] irq_clear_mask;
  reg [`IRQ_WIDTH-1:0] next_irq_status;
  always @* begin
    irq_clear_mask = {`IRQ_WIDTH{1'b0}};
    if (wr_clr) begin
      irq_clear_mask = w_data[`IRQ_WIDTH-1:0];
    end
    next_irq_status = (irq_status & ~irq_clear_mask) | irq_events;
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      protect_violation_flag <= 1'b0;
      irq_status <= {`IRQ_WIDTH{1'b0}};
      irq_enable <= {`IRQ_WIDTH{1'b0}};
    end else begin
      // a new event in the clearing cycle keeps the flag set
      if (viol_event) begin
        protect_violation_flag <= 1'b1; // RULE12
      end else if (viol_clear) begin
        protect_violation_flag <= 1'b0; // RULE18
      end
      irq_status <= next_irq_status;
      if (wr_en) begin
        irq_enable <= w_data[`IRQ_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  // level output: stays high until software clears the status bit or masks it
  assign irq = |(irq_status & irq_enable);

  // lock state is exported on reads only; kept visible for debug use
  wire unused_secured = secured;

endmodule // flash_prot

/* File: verif/flash_prot_monitor.sv */
// Purpose: port checker for flash_prot
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every flash_prot instance
// ----------------------------------------
// checker
// ----------------------------------------
module flash_prot_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // array port
  input wire logic array_wr,
  input wire logic array_rd,
  input wire logic array_erase,
  input wire logic mass_erase,
  input wire logic cmd_write,
  input wire logic key_write,
  input wire logic array_read_ok,
  input wire logic erase_go,
  input wire logic mass_erase_go,
  input wire logic cmd_launch_ok
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_read_served: assert property (array_read_ok == array_rd)
    else $error("array read not served");
  a_key_route: assert property (array_wr && key_write |-> !cmd_write)
    else $error("key write also started a command");
  a_flag_blocks: assert property (!cmd_launch_ok |-> !(cmd_write || erase_go || mass_erase_go))
    else $error("operation let through while violation flag set");
  a_flag_cause: assert property ($fell(cmd_launch_ok) |-> $past(array_wr || array_erase || mass_erase))
    else $error("violation flag set without a request");
  a_mass_cause: assert property (mass_erase_go |-> mass_erase)
    else $error("mass erase go without request");
  a_erase_cause: assert property (erase_go |-> array_erase)
    else $error("erase go without request");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  c_violation: cover property ($fell(cmd_launch_ok));
  c_key: cover property (key_write);
  c_mass: cover property (mass_erase_go);
endmodule // flash_prot_monitor

bind flash_prot flash_prot_monitor u_mon (.*);

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for flash_prot
// Assumes: reads scored through a queue of expected words
// Notes: array port outputs are compared 2 ns after the driving edge
`include "flash_prot_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset_n, load_strobe, awvalid, wvalid, bready, arvalid, rready;
  logic aw_rdy, w_rdy, b_val, ar_rdy, r_val, a_wr, a_rd, a_er, m_er, k_match;
  logic c_wr, k_wr, rd_ok, er_go, m_go, launch_ok, irq;
  logic [7:0] opt_b, prot_b;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [16:0] a_addr, top;
  logic [6:0] sz;
  logic [33:0] exp_q[$];
  int err_total, n_compared;
  flash_prot dut (.mclk(mclk), .reset_n(reset_n), .load_strobe(load_strobe),
    .stored_options_byte(opt_b), .stored_protection_byte(prot_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(aw_rdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(b_val),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(ar_rdy),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_val), .s_axi_rready(rready),
    .array_wr(a_wr), .array_rd(a_rd), .array_erase(a_er), .mass_erase(m_er), .array_addr(a_addr),
    .key_match(k_match), .cmd_write(c_wr), .key_write(k_wr), .array_read_ok(rd_ok),
    .erase_go(er_go), .mass_erase_go(m_go), .cmd_launch_ok(launch_ok), .irq(irq));
  // ----------------------------------------
  // clock, scoring and closing
  // ----------------------------------------
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input [33:0] g, input [33:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  always @(posedge mclk) if (r_val && rready) chk({rresp, rdata}, exp_q.pop_front());
  task tally_and_finish;
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    tally_and_finish;
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task wr(input [5:0] a, input [7:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (aw_rdy) awvalid <= 0;
      if (w_rdy) wvalid <= 0;
    end while (!b_val);
    bready <= 0;
  endtask
  task rd(input [5:0] a, input [33:0] e);
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    exp_q.push_back(e);
    do begin
      @(posedge mclk);
      if (ar_rdy) arvalid <= 0;
    end while (!r_val);
    rready <= 0;
  endtask
  task ld(input [7:0] o, input [7:0] p);
    @(posedge mclk);
    {load_strobe, opt_b, prot_b} <= {1'b1, o, p};
    @(posedge mclk);
    load_strobe <= 0;
  endtask
  // req is {write, erase, mass erase, key match}; result {cmd, key, erase, mass, read}
  task arr(input [3:0] req, input [16:0] a, input [4:0] e);
    @(posedge mclk);
    {a_wr, a_er, m_er, k_match, a_rd, a_addr} <= {req, 1'b1, a};
    #2 chk({c_wr, k_wr, er_go, m_go, rd_ok}, e);
    @(posedge mclk);
    {a_wr, a_er, m_er, k_match, a_rd} <= 5'h0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h7d3d));
    {reset_n, load_strobe, opt_b, prot_b, awaddr, araddr, wdata} = 0;
    {awvalid, wvalid, bready, arvalid, rready, a_wr, a_rd, a_er, m_er, k_match, a_addr} = 0;
    {err_total, n_compared} = 0;
    repeat (4) @(posedge mclk);
    reset_n <= 1;
    rd(`OFS_SECTOR_PROT, 34'h0);
    arr(4'h4, 17'($urandom), 5'h01);
    wr(`OFS_FLASH_STATUS, 8'h00);
    rd(`OFS_FLASH_STATUS, 34'h20);
    wr(`OFS_IRQ_ENABLE, 8'h01);
    rd(`OFS_IRQ_STATUS, 34'h1);
    chk(irq, 1);
    wr(`OFS_IRQ_ENABLE, 8'h00);
    chk(irq, 0);
    wr(`OFS_IRQ_CLEAR, 8'h07);
    rd(`OFS_IRQ_STATUS, 34'h0);
    wr(`OFS_FLASH_STATUS, 8'h20);
    rd(`OFS_FLASH_STATUS, 34'h0);
    rd(6'h3C, {`AXI_SLVERR, 32'h0});
    // last pass leaves the backdoor enabled
    for (int i = 3; i < 7; i++) begin
      ld({i[1:0], 6'h02}, 8'hFF);
      wr(`OFS_SECURITY_OPTIONS, 8'h00);
      wr(`OFS_BACKDOOR_GATE, 8'hFF);
      rd(`OFS_SECURITY_OPTIONS, {26'h0, i[1:0], 6'h02});
      rd(`OFS_BACKDOOR_GATE, (i == 6) ? 34'h20 : 34'h0);
    end
    arr(4'h8, 17'($urandom), 5'h09);
    arr(4'h9, 17'($urandom), 5'h09);
    rd(`OFS_SECURITY_OPTIONS, 34'h83);
    wr(`OFS_BACKDOOR_GATE, 8'h00);
    arr(4'h8, 17'($urandom), 5'h11);
    arr(4'h2, 17'h0, 5'h03);
    for (int j = 0; j < 3; j++) begin
      sz = (j == 0) ? 7'h40 : (j == 1) ? 7'h5F : 7'h7E;
      ld(8'h00, {sz, 1'b1});
      top = {6'(7'h7F - sz), 11'h000};
      arr(4'h4, top, 5'h05);
      arr(4'h2, 17'h0, 5'h01);
      arr(4'h4, top - 17'h1, 5'h01);
      rd(`OFS_FLASH_STATUS, 34'h20);
      arr(4'h8, top + 17'($urandom % (32'h20000 - top)), 5'h01);
      wr(`OFS_FLASH_STATUS, 8'h20);
    end
    wr(`OFS_SECTOR_PROT, 8'hFF);
    rd(`OFS_SECTOR_PROT, 34'hFD);
    wr(`OFS_SECTOR_PROT, 8'hBB);
    rd(`OFS_SECTOR_PROT, 34'hBB);
    wr(`OFS_SECTOR_PROT, 8'hBD);
    rd(`OFS_SECTOR_PROT, 34'hBB);
    wr(`OFS_SECTOR_PROT, 8'h7D);
    rd(`OFS_SECTOR_PROT, 34'h7D);
    wr(`OFS_SECTOR_PROT, 8'h81);
    rd(`OFS_SECTOR_PROT, 34'h7D);
    arr(4'h4, 17'h1FFFF, 5'h01);
    tally_and_finish;
  end
endmodule // tb_top
